// ---- logic/rcr_reset_seq.v ----
// Reset-cause recorder and system reset sequencer, with the cause and
// enable register on the special-function register port.
// Assumes all inputs are synchronous to mclk; rst is the power-on reset.
//
// Functional notes
// [RQ1] Flash fault flag reads 1 after a reset from an illegal flash access.
// [RQ2] Writing 1 enables comparator reset; reads 1 if comparator caused last reset.
// [RQ3] Writing 1 to software bit forces a full system reset at once.
// [RQ4] Software bit reads 1 after a software forced reset.
// [RQ5] Watchdog flag reads 1 after a watchdog overflow reset.
// [RQ6] Writing 1 enables clock loss detector; flag reads 1 after its reset.
// [RQ7] Writing 1 to power-on bit selects supply monitor as reset source.
// [RQ8] Software lets the supply monitor settle before selecting it.
// [RQ9] Power-on flag reads 1 after power-on or monitor reset; others indeterminate.
// [RQ10] Pin flag reads 1 after a reset from the external pin.
// [RQ11] Software avoids read-modify-write on the cause register.
// [RQ12] Writing 0 disables the clock loss detector, writing 1 enables it.
// [RQ13] With comparator reset enabled, reset while noninverting input is lower.
// [RQ14] Flash access above user code space causes a flash fault reset.
// [RQ15] Bit 7 always reads 0; writes to it are ignored.
// [RQ16] Each new reset clears stale flags; only the latest cause reads 1.
`timescale 1ns/10ps
`default_nettype none
`include "rcr_regs.vh"

module rcr_reset_seq #(
  parameter        ADDR_W   = 16,
  parameter [15:0] HOLD_CYC = `RCR_HOLD_CYC
) (
  input  wire              mclk,
  input  wire              rst,
  input  wire              ce,
  input  wire [7:0]        sfrAddr,
  input  wire              sfrWrite,
  input  wire              sfrRead,
  input  wire [7:0]        sfrWdata,
  output reg  [7:0]        sfrRdata,
  input  wire              rstPinN,
  input  wire              monitorAbove,
  input  wire              clockLossDetect,
  input  wire              watchdogOverflow,
  input  wire              compOut,
  input  wire              flashWrEn,
  input  wire              flashRd,
  input  wire              progFetch,
  input  wire              securityDeny,
  input  wire [ADDR_W-1:0] flashAddr,
  output wire              sysReset,
  output wire              monitorResetEn,
  output wire              clockLossEn,
  output wire              compResetEn
);

  // ************************************************************
  // Local definitions
  // ************************************************************
  localparam [0:0] ST_RUN  = 1'b0;
  localparam [0:0] ST_HOLD = 1'b1;

  function regHit;
    input [7:0] addr;
    begin
      regHit = (addr == `RCR_CAUSE_ADDR);
    end
  endfunction

  reg  [0:0]  state_q;
  reg  [0:0]  state_d;
  reg  [15:0] holdCnt_q;
  reg  [15:0] holdCnt_d;
  reg  [6:0]  flags_q;
  reg  [6:0]  flags_d;
  reg         monEn_q;
  reg         clkEn_q;
  reg         cmpEn_q;
  reg  [6:0]  cause;
  reg  [7:0]  readValue;
  wire        flashFault;
  wire        wrHit;
  wire        swForce;
  wire        pinEvent;
  wire        monEvent;
  wire        clkEvent;
  wire        cmpEvent;
  wire        anyEvent;
  wire        holdExtend;

  // ************************************************************
  // Reset sources
  // ************************************************************
  rcr_flash_guard #(
    .ADDR_W   (ADDR_W)
  ) uGuard (
    .flashWrEn    (flashWrEn),
    .flashRd      (flashRd),
    .progFetch    (progFetch),
    .securityDeny (securityDeny),
    .flashAddr    (flashAddr),
    .flashFault   (flashFault)
  );

  assign wrHit    = sfrWrite & regHit(sfrAddr);
  assign swForce  = wrHit & sfrWdata[`RCR_SW_BIT];             // [RQ3]
  assign pinEvent = ~rstPinN;
  assign monEvent = monEn_q & ~monitorAbove;                   // [RQ7]
  assign clkEvent = clkEn_q & clockLossDetect;                 // [RQ6]
  // Comparator output is low while the noninverting input is below
  assign cmpEvent = cmpEn_q & ~compOut;                        // [RQ13]
  assign anyEvent = pinEvent | monEvent | clkEvent | flashFault |
                    watchdogOverflow | cmpEvent | swForce;

  // A held pin or a low supply keeps the system in reset past the minimum
  assign holdExtend = pinEvent | monEvent;

  // ************************************************************
  // Cause selection
  // ************************************************************
  // One-hot, so only the newest cause survives; supply beats all others
  always @* begin
    cause = 7'h00;
    if (monEvent) begin
      cause[`RCR_POR_BIT] = 1'b1;                              // [RQ9]
    end else if (pinEvent) begin
      cause[`RCR_PIN_BIT] = 1'b1;                              // [RQ10]
    end else if (clkEvent) begin
      cause[`RCR_CLK_BIT] = 1'b1;                              // [RQ6]
    end else if (flashFault) begin
      cause[`RCR_FLASH_BIT] = 1'b1;                            // [RQ1]
    end else if (watchdogOverflow) begin
      cause[`RCR_WDT_BIT] = 1'b1;                              // [RQ5]
    end else if (cmpEvent) begin
      cause[`RCR_CMP_BIT] = 1'b1;                              // [RQ2]
    end else if (swForce) begin
      cause[`RCR_SW_BIT] = 1'b1;                               // [RQ4]
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  always @* begin
    state_d   = state_q;
    holdCnt_d = holdCnt_q;
    flags_d   = flags_q;
    case (state_q)
      ST_RUN: begin
        if (anyEvent) begin
          state_d   = ST_HOLD;                                 // [RQ3]
          holdCnt_d = HOLD_CYC;
          flags_d   = cause;                                   // [RQ16]
        end
      end
      ST_HOLD: begin
        if (holdCnt_q != 16'h0000) begin
          holdCnt_d = holdCnt_q - 16'h0001;
        end else if (!holdExtend) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_HOLD;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      state_q   <= ST_HOLD;
      holdCnt_q <= HOLD_CYC;
      flags_q   <= `RCR_FLAGS_RST;                             // [RQ9]
    end else if (ce) begin
      state_q   <= state_d;
      holdCnt_q <= holdCnt_d;
      flags_q   <= flags_d;
    end
  end

  // ************************************************************
  // Enables
  // ************************************************************
  // Clock loss and comparator enables drop on every system reset; the
  // monitor selection survives all resets but power-on
  always @(posedge mclk) begin
    if (rst) begin
      monEn_q <= `RCR_MON_EN_RST;
      clkEn_q <= `RCR_CLK_EN_RST;
      cmpEn_q <= `RCR_CMP_EN_RST;
    end else if (ce) begin
      if (state_q == ST_HOLD) begin
        clkEn_q <= `RCR_CLK_EN_RST;
        cmpEn_q <= `RCR_CMP_EN_RST;
      end else if (wrHit) begin
        // A write that also forces a reset still lands; the hold clears its clock loss and comparator enables
        monEn_q <= sfrWdata[`RCR_POR_BIT];                     // [RQ7]
        clkEn_q <= sfrWdata[`RCR_CLK_BIT];                     // [RQ12]
        cmpEn_q <= sfrWdata[`RCR_CMP_BIT];                     // [RQ2]
      end
    end
  end

  assign monitorResetEn = monEn_q;
  assign clockLossEn    = clkEn_q;
  assign compResetEn    = cmpEn_q;
  assign sysReset       = (state_q == ST_HOLD);

  // ************************************************************
  // Read port
  // ************************************************************
  // Reads show flags, not enables: a read-modify-write can fire a reset
  always @* begin
    readValue = {1'b0, flags_q};                               // [RQ15]
  end

  always @(posedge mclk) begin
    if (rst) begin
      sfrRdata <= 8'h00;
    end else if (ce) begin
      if (sfrRead && regHit(sfrAddr)) begin
        sfrRdata <= readValue;
      end else begin
        sfrRdata <= 8'h00;
      end
    end
  end

endmodule

`default_nettype wire

// ---- logic/rcr_regs.vh ----
// Register map, field positions, reset values and timing counts of the
// reset-cause recorder.
// Assumes it is included by bare name from files under logic/.
`ifndef RCR_REGS_VH
`define RCR_REGS_VH

// ************************************************************
// Register address
// ************************************************************
`define RCR_CAUSE_ADDR      8'hEF

// ************************************************************
// Field positions of reset_cause_and_enable
// ************************************************************
`define RCR_PIN_BIT         0
`define RCR_POR_BIT         1
`define RCR_CLK_BIT         2
`define RCR_WDT_BIT         3
`define RCR_SW_BIT          4
`define RCR_CMP_BIT         5
`define RCR_FLASH_BIT       6
`define RCR_UNUSED_BIT      7

// ************************************************************
// Reset values
// ************************************************************
`define RCR_FLAGS_RST       7'h02
`define RCR_MON_EN_RST      1'b1
`define RCR_CLK_EN_RST      1'b0
`define RCR_CMP_EN_RST      1'b0

// ************************************************************
// Flash limit and timing
// ************************************************************
`define RCR_FLASH_TOP       16'h3DFF
`define RCR_MCLK_PERIOD_NS  20
`define RCR_HOLD_NS         200
// RCR_HOLD_NS over RCR_MCLK_PERIOD_NS, sized to fit the 16-bit hold counter
`define RCR_HOLD_CYC        16'h000A

`endif

// ---- logic/rcr_flash_guard.v ----
// Flash access guard: flags any access aimed above user code space,
// or any access refused by the flash security setting.
// Assumes access strobes and address are synchronous to mclk.
`timescale 1ns/10ps
`default_nettype none
`include "rcr_regs.vh"

module rcr_flash_guard #(
  parameter              ADDR_W   = 16,
  parameter [ADDR_W-1:0] USER_TOP = `RCR_FLASH_TOP
) (
  input  wire              flashWrEn,
  input  wire              flashRd,
  input  wire              progFetch,
  input  wire              securityDeny,
  input  wire [ADDR_W-1:0] flashAddr,
  output wire              flashFault
);

  wire anyAccess;

  assign anyAccess  = flashWrEn | flashRd | progFetch;
  // Security refusals count only when an access is really attempted
  assign flashFault = anyAccess & ((flashAddr > USER_TOP) | securityDeny); // [RQ14]

endmodule

`default_nettype wire

// ---- dv/rcr_monitor.sv ----
// Checker on the top ports of the reset-cause recorder.
// Assumes one mclk domain with rst active high.
`timescale 1ns/10ps
`default_nettype none
module rcr_monitor #(
  parameter [15:0] HOLD_CYC = 16'h000A
) (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic       sfrWrite,
  input wire logic       rstPinN,
  input wire logic       clockLossDetect,
  input wire logic       watchdogOverflow,
  input wire logic       compOut,
  input wire logic       sysReset,
  input wire logic       monitorResetEn,
  input wire logic       clockLossEn,
  input wire logic       compResetEn,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWdata,
  input wire logic [7:0] sfrRdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic [15:0] hold_q;
  wire         run = ce && !sysReset;
  wire         wr = run && sfrWrite && sfrAddr == 8'hEF;
  // Length of the current reset, judged at the edge where it ends
  always @(posedge mclk) hold_q <= (rst || !sysReset) ? 16'h0000 : hold_q + 16'h0001;
  a_sw_force: assert property (wr && sfrWdata[4] |=> sysReset) else $error("reset missed");
  a_hold_min: assert property ($fell(sysReset) |-> hold_q >= HOLD_CYC) else $error("reset short");
  a_wdt_reset: assert property (run && watchdogOverflow |=> sysReset) else $error("reset missed");
  a_pin_level: assert property (ce && !rstPinN |=> sysReset) else $error("reset missed");
  a_clk_reset: assert property (run && clockLossEn && clockLossDetect |=> sysReset) else $error("reset missed");
  a_clk_off: assert property (wr && !sfrWdata[2] |=> !clockLossEn) else $error("detector on");
  a_cmp_reset: assert property (run && compResetEn && !compOut |=> sysReset) else $error("reset missed");
  a_bit7_zero: assert property (!sfrRdata[7]) else $error("bit 7 set");
  a_mon_select: assert property (wr |=> monitorResetEn == $past(sfrWdata[1])) else $error("monitor select");
endmodule
bind rcr_reset_seq rcr_monitor #(.HOLD_CYC(HOLD_CYC)) uMon (.mclk(mclk), .rst(rst), .ce(ce), .sfrWrite(sfrWrite),
  .rstPinN(rstPinN), .clockLossDetect(clockLossDetect), .watchdogOverflow(watchdogOverflow), .compOut(compOut),
  .sysReset(sysReset), .monitorResetEn(monitorResetEn), .clockLossEn(clockLossEn), .compResetEn(compResetEn),
  .sfrAddr(sfrAddr), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata));
`default_nettype wire

// ---- dv/rcr_src_model.sv ----
// Model of the on-chip reset sources; kind names the one that fires.
// Assumes kind changes on the falling edge of mclk.
`timescale 1ns/10ps
`default_nettype none
module rcr_src_model (
  input  wire logic       mclk,
  input  wire logic [2:0] kind,
  output wire logic       rstPinN, monitorAbove, clockLossDetect, watchdogOverflow, compOut, flashRd
);
  logic [2:0] kind_q = 3'h0;
  // Latched on the falling edge so each source is steady for a whole cycle
  always @(negedge mclk) kind_q <= kind;
  assign rstPinN = kind_q != 3'h1;
  assign monitorAbove = kind_q != 3'h2;
  assign clockLossDetect = kind_q == 3'h3;
  assign watchdogOverflow = kind_q == 3'h4;
  assign compOut = kind_q != 3'h5;
  assign flashRd = kind_q == 3'h6;
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench of the reset-cause recorder.
// Assumes the source model, and the checker bound to the design.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        mclk = 1'b0, rst = 1'b1, sfrWrite = 1'b0, sfrRead = 1'b0, rdLast = 1'b0, wrLast = 1'b0;
  logic [7:0]  sfrWdata = 8'h00, sfrAddr = 8'hEF, sfrRdata, expQ[$];
  logic [2:0]  kind = 3'h0, expE[$];
  logic [15:0] flashAddr = 16'h0000;
  logic        rstPinN, monitorAbove, clockLossDetect, watchdogOverflow, compOut, flashRd, sysReset;
  logic        monitorResetEn, clockLossEn, compResetEn;
  int          mismatches = 0, total_checks = 0, cycles = 0;
  integer      seed = 32'h27FD48C5;
  // Each step: data written, source fired, cause byte expected
  logic [23:0] steps [12] = '{
    24'h800002,
    24'h100010,
    24'h020408,
    24'h020101,
    24'h000301,
    24'h000501,
    24'h040304,
    24'h200520,
    24'h000620,
    24'h000640,
    24'h000240,
    24'h020202};
  always #10 mclk = ~mclk;
  rcr_src_model SRC (.mclk(mclk), .kind(kind), .rstPinN(rstPinN), .monitorAbove(monitorAbove),
    .clockLossDetect(clockLossDetect), .watchdogOverflow(watchdogOverflow), .compOut(compOut), .flashRd(flashRd));
  rcr_reset_seq #(.HOLD_CYC(16'h0002)) DUT (.mclk(mclk), .rst(rst), .ce(1'b1), .sfrAddr(sfrAddr),
    .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .rstPinN(rstPinN),
    .monitorAbove(monitorAbove), .clockLossDetect(clockLossDetect), .watchdogOverflow(watchdogOverflow),
    .compOut(compOut), .flashWrEn(1'b0), .flashRd(flashRd), .progFetch(1'b0), .securityDeny(1'b0),
    .flashAddr(flashAddr), .sysReset(sysReset), .monitorResetEn(monitorResetEn), .clockLossEn(clockLossEn),
    .compResetEn(compResetEn));
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(logic [7:0] e);
    total_checks++;
    if (sfrRdata !== e) begin
      mismatches++;
      $display("wrong value sfrRdata expected %h seen %h", e, sfrRdata);
    end
  endtask
  // Enables in the order monitor, clock loss, comparator
  task automatic chkEn(logic [2:0] e);
    total_checks++;
    if ({monitorResetEn, clockLossEn, compResetEn} !== e) begin
      mismatches++;
      $display("wrong value enables expected %b seen %b", e, {monitorResetEn, clockLossEn, compResetEn});
    end
  endtask
  // Whole-byte access; a gap cycle keeps strobes from being set twice at once
  task automatic op(logic w, logic [7:0] d);
    sfrWrite <= w;
    sfrRead <= !w;
    sfrWdata <= d;
    @(negedge mclk);
    sfrWrite <= 1'b0;
    sfrRead <= 1'b0;
    @(negedge mclk);
  endtask
  task automatic ev(logic [2:0] k);
    kind <= k;
    @(negedge mclk);
    kind <= 3'h0;
    repeat (3) @(negedge mclk);
    for (int n = 0; n < 40 && sysReset !== 1'b0; n++) @(negedge mclk);
  endtask
  always @(posedge mclk) begin
    rdLast <= sfrRead;
    wrLast <= sfrWrite && sfrAddr == 8'hEF;
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      conclude;
    end
  end
  always @(negedge mclk) if (rdLast) chk(expQ.pop_front());
  always @(negedge mclk) if (wrLast) chkEn(expE.pop_front());
  initial begin
    repeat (4) @(negedge mclk);
    rst <= 1'b0;
    ev(3'h0);
    foreach (steps[i]) begin
      flashAddr <= (i == 8) ? 16'h3DFF : 16'h3E00 | 16'($random(seed));
      expE.push_back({steps[i][17], steps[i][18], steps[i][21]});
      op(1'b1, steps[i][23:16]);
      ev(steps[i][10:8]);
      expQ.push_back(steps[i][7:0]);
      op(1'b0, 8'h00);
    end
    // Another address: reads return 0 and a force bit is not decoded
    sfrAddr <= 8'hEE;
    expQ.push_back(8'h00);
    op(1'b0, 8'h00);
    op(1'b1, 8'h10);
    sfrAddr <= 8'hEF;
    ev(3'h0);
    expQ.push_back(8'h02);
    op(1'b0, 8'h00);
    repeat (2) @(negedge mclk);
    conclude;
  end
endmodule
`default_nettype wire
